// ---- rtl/ubd_top.sv ----
// serial port with baud divisor, data buffer and axi4-lite registers
//
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ubd_consts.svh"
module ubd_top import ubd_pkg::*; #(
	parameter int ADDR_W = 12 // byte address width
) (
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	// axi4-lite write data
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	// axi4-lite read data
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// serial line
	input wire logic rxd,
	output logic txd,
	// level interrupt
	output logic irq
);
	// ----------------------------------------
	// write channel capture
	// ----------------------------------------
	logic aw_held_r; // address taken, waiting for data
	logic [ADDR_W-1:0] aw_addr_r;
	logic w_held_r; // data taken, waiting for address
	logic [7:0] w_byte_r; // only the low lane is implemented
	logic w_lane_r; // low byte lane enabled
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic wr_fire; // both halves present, response free
	logic [7:0] wr_idx;
	logic wr_hit; // word index inside the map
	logic wr_ctl;
	logic wr_div_hi;
	logic wr_div_lo;
	logic wr_data;
	logic wr_stat;
	logic wr_mask;

	// accept each half once; hold it until the pair is complete
	assign awready = !aw_held_r;
	assign wready = !w_held_r;
	assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
	assign wr_idx = aw_addr_r[9:2];
	assign wr_hit = (aw_addr_r[ADDR_W-1:10] == '0);
	// writes with the low lane off are acknowledged but change nothing
	assign wr_ctl = wr_fire && wr_hit && w_lane_r && wr_idx == `UBD_IDX_CTL;
	assign wr_div_hi = wr_fire && wr_hit && w_lane_r && wr_idx == `UBD_IDX_DIV_HI;
	assign wr_div_lo = wr_fire && wr_hit && w_lane_r && wr_idx == `UBD_IDX_DIV_LO;
	assign wr_data = wr_fire && wr_hit && w_lane_r && wr_idx == `UBD_IDX_DATA;
	assign wr_stat = wr_fire && wr_hit && w_lane_r && wr_idx == `UBD_IDX_IRQ_STAT;
	assign wr_mask = wr_fire && wr_hit && w_lane_r && wr_idx == `UBD_IDX_IRQ_MASK;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;

	// write address holding register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= '0;
		end else if (awvalid && awready) begin
			aw_held_r <= 1'b1;
			aw_addr_r <= awaddr;
		end else if (wr_fire) begin
			aw_held_r <= 1'b0;
		end
	end

	// write data holding register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			w_byte_r <= `UBD_RST_BYTE;
			w_lane_r <= 1'b0;
		end else if (wvalid && wready) begin
			w_held_r <= 1'b1;
			w_byte_r <= wdata[7:0];
			w_lane_r <= wstrb[0];
		end else if (wr_fire) begin
			w_held_r <= 1'b0;
		end
	end

	// write response; unmapped words answer slverr
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_r <= 1'b0;
			bresp_r <= `UBD_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_r <= 1'b1;
			bresp_r <= (wr_hit && (wr_idx == `UBD_IDX_CTL || wr_idx == `UBD_IDX_DIV_HI ||
				wr_idx == `UBD_IDX_DIV_LO || wr_idx == `UBD_IDX_DATA ||
				wr_idx == `UBD_IDX_IRQ_STAT || wr_idx == `UBD_IDX_IRQ_MASK)) ?
				`UBD_RESP_OKAY : `UBD_RESP_SLVERR;
		end else if (bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// configuration registers
	// ----------------------------------------
	logic fmt_r; // frame_format_select: 1 selects the long frame
	logic mp_r; // multiproc_filter
	logic ren_r; // receive enable
	logic tb8_r; // tx_ninth_bit
	logic [7:0] div_hi_r; // divisor_high_byte
	logic [7:0] div_lo_r; // divisor_low_byte
	logic [15:0] divisor;

	// changing the divisor mid frame stretches or shortens the bit in flight
	assign divisor = {div_hi_r, div_lo_r};

	// control bits owned by software alone
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fmt_r <= 1'b0;
			mp_r <= 1'b0;
			ren_r <= 1'b0;
			tb8_r <= 1'b0;
		end else if (wr_ctl) begin
			fmt_r <= w_byte_r[`UBD_CTL_FMT];
			mp_r <= w_byte_r[`UBD_CTL_MP];
			ren_r <= w_byte_r[`UBD_CTL_REN];
			tb8_r <= w_byte_r[`UBD_CTL_TB8];
		end
	end

	// baud divisor bytes
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_hi_r <= `UBD_RST_BYTE;
			div_lo_r <= `UBD_RST_BYTE;
		end else begin
			if (wr_div_hi) begin
				div_hi_r <= w_byte_r;
			end
			if (wr_div_lo) begin
				div_lo_r <= w_byte_r;
			end
		end
	end

	// ----------------------------------------
	// transmitter and receiver
	// ----------------------------------------
	logic tx_done; // one-cycle pulse after the stop bit
	logic [7:0] rx_byte;
	logic rx_ninth;
	logic rx_done; // one-cycle pulse after a good stop bit
	logic rx_accept; // frame passes the address filter

	// the transmit shifter takes the byte straight from the bus
	ubd_tx ubd_tx_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.divisor(divisor),
		.long_frame(fmt_r),
		.start(wr_data),
		.data(w_byte_r),
		.ninth(tb8_r),
		.txd(txd),
		.done(tx_done)
	);

	ubd_rx ubd_rx_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.divisor(divisor),
		.long_frame(fmt_r),
		.enable(ren_r),
		.rxd(rxd),
		.data(rx_byte),
		.ninth(rx_ninth),
		.done(rx_done)
	);

	// filter only acts in the long frame
	assign rx_accept = rx_done && !(fmt_r && mp_r && !rx_ninth);

	// ----------------------------------------
	// flags and receive latch
	// ----------------------------------------
	logic ti_r; // tx_done_flag
	logic ri_r; // rx_done_flag
	logic rb8_r; // rx_ninth_bit
	logic [7:0] rx_latch_r; // separate from the transmit byte

	// hardware set wins over a same-cycle software write
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ti_r <= 1'b0;
			ri_r <= 1'b0;
		end else begin
			if (tx_done) begin
				ti_r <= 1'b1;
			end else if (wr_ctl) begin
				ti_r <= w_byte_r[`UBD_CTL_TI];
			end
			if (rx_accept) begin
				ri_r <= 1'b1;
			end else if (wr_ctl) begin
				ri_r <= w_byte_r[`UBD_CTL_RI];
			end
		end
	end

	// ninth bit is caught even when the filter drops the frame
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rb8_r <= 1'b0;
		end else if (rx_done && fmt_r) begin
			rb8_r <= rx_ninth;
		end else if (wr_ctl) begin
			rb8_r <= w_byte_r[`UBD_CTL_RB8];
		end
	end

	// a filtered frame leaves the previous byte readable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rx_latch_r <= `UBD_RST_BYTE;
		end else if (rx_accept) begin
			rx_latch_r <= rx_byte;
		end
	end

	// ----------------------------------------
	// interrupt status and mask
	// ----------------------------------------
	logic [1:0] irq_stat_r; // sticky events, write one to clear
	logic [1:0] irq_mask_r; // one enables the event onto irq
	logic [1:0] irq_set;

	assign irq_set[`UBD_IRQ_RX] = rx_accept;
	assign irq_set[`UBD_IRQ_TX] = tx_done;
	assign irq = |(irq_stat_r & irq_mask_r);

	// set beats clear when both land together
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= 2'h0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~(wr_stat ? w_byte_r[1:0] : 2'h0)) | irq_set;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask_r <= 2'h0;
		end else if (wr_mask) begin
			irq_mask_r <= w_byte_r[1:0];
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	logic [7:0] rd_idx;
	logic rd_hit;
	logic [7:0] ctl_view;

	assign arready = !rvalid_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign rd_idx = araddr[9:2];
	assign rd_hit = (araddr[ADDR_W-1:10] == '0);
	// reserved bit 6 reads zero
	assign ctl_view = {fmt_r, 1'b0, mp_r, ren_r, tb8_r, rb8_r, ti_r, ri_r};

	// answer one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= `UBD_RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_r <= 1'b1;
			rresp_r <= `UBD_RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			if (!rd_hit) begin
				rresp_r <= `UBD_RESP_SLVERR;
			end else begin
				unique case (rd_idx)
					`UBD_IDX_CTL: rdata_r[7:0] <= ctl_view;
					`UBD_IDX_DIV_HI: rdata_r[7:0] <= div_hi_r;
					`UBD_IDX_DIV_LO: rdata_r[7:0] <= div_lo_r;
					`UBD_IDX_DATA: rdata_r[7:0] <= rx_latch_r;
					`UBD_IDX_IRQ_STAT: rdata_r[1:0] <= irq_stat_r;
					`UBD_IDX_IRQ_MASK: rdata_r[1:0] <= irq_mask_r;
					default: rresp_r <= `UBD_RESP_SLVERR;
				endcase
			end
		end else if (rready) begin
			rvalid_r <= 1'b0;
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_ninth_capture;
		rx_done && fmt_r |=> rb8_r == $past(rx_ninth);
	endproperty
	a_ninth_capture: assert property (p_ninth_capture) else $error("ninth bit not captured");

	property p_ti_cleared;
		wr_ctl && !w_byte_r[`UBD_CTL_TI] && !tx_done |=> !ti_r;
	endproperty
	a_ti_cleared: assert property (p_ti_cleared) else $error("tx flag not cleared");

	property p_ri_cleared;
		wr_ctl && !w_byte_r[`UBD_CTL_RI] && !rx_accept |=> !ri_r;
	endproperty
	a_ri_cleared: assert property (p_ri_cleared) else $error("rx flag not cleared");

	property p_filter;
		rx_done && fmt_r && mp_r && !rx_ninth && !wr_ctl |=> ri_r == $past(ri_r);
	endproperty
	a_filter: assert property (p_filter) else $error("filtered frame raised flag");

	property p_flag_set;
		tx_done |=> ti_r && irq_stat_r[`UBD_IRQ_TX];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("tx flag not set at stop");

	property p_flag_sticky;
		ri_r && !wr_ctl |=> ri_r;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("rx flag dropped");

	property p_read_latch;
		arvalid && arready && rd_hit && rd_idx == `UBD_IDX_DATA |=> rvalid && rdata[7:0] == $past(rx_latch_r);
	endproperty
	a_read_latch: assert property (p_read_latch) else $error("data read not receive latch");

	property p_tx_begins;
		wr_data |=> ##[0:1] !txd;
	endproperty
	a_tx_begins: assert property (p_tx_begins) else $error("write did not start frame");
endmodule : ubd_top

// ---- rtl/ubd_consts.svh ----
// register offsets, field positions and reset values of the serial port
`ifndef UBD_CONSTS_SVH
`define UBD_CONSTS_SVH
// register indices; byte address is four times the index
`define UBD_IDX_CTL 8'h9D
`define UBD_IDX_DIV_HI 8'h95
`define UBD_IDX_DIV_LO 8'h9E
`define UBD_IDX_DATA 8'h9F
`define UBD_IDX_IRQ_STAT 8'hA0
`define UBD_IDX_IRQ_MASK 8'hA1
// control register fields
`define UBD_CTL_FMT 7
`define UBD_CTL_MP 5
`define UBD_CTL_REN 4
`define UBD_CTL_TB8 3
`define UBD_CTL_RB8 2
`define UBD_CTL_TI 1
`define UBD_CTL_RI 0
// interrupt status and mask fields
`define UBD_IRQ_RX 0
`define UBD_IRQ_TX 1
// reset values
`define UBD_RST_BYTE 8'h00
// frame lengths in bit times
`define UBD_LEN_SHORT 4'hA
`define UBD_LEN_LONG 4'hB
// axi responses
`define UBD_RESP_OKAY 2'h0
`define UBD_RESP_SLVERR 2'h2
`endif

// ---- rtl/ubd_pkg.sv ----
// types shared by the serial port modules
package ubd_pkg;
	typedef enum logic [1:0] {
		RX_IDLE,
		RX_START,
		RX_DATA,
		RX_STOP
	} ubd_rx_state_t;
endpackage : ubd_pkg

// ---- rtl/ubd_tx.sv ----
// serial transmitter: one frame per start pulse
`timescale 1ns/1ps
`include "ubd_consts.svh"
module ubd_tx import ubd_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] divisor,
	input wire logic long_frame,
	input wire logic start,
	input wire logic [7:0] data,
	input wire logic ninth,
	output logic txd,
	output logic done
);
	// ----------------------------------------
	// bit timing and shifting
	// ----------------------------------------
	logic [10:0] shift_r; // rest of frame, lsb next
	logic [15:0] cnt_r; // clocks within bit
	logic [3:0] idx_r; // bit index in frame
	logic busy_r;
	logic txd_r;
	logic done_r;
	logic tick;
	logic [3:0] last_idx;
	assign tick = busy_r && (cnt_r == divisor - 16'h0001);
	assign last_idx = (long_frame ? `UBD_LEN_LONG : `UBD_LEN_SHORT) - 4'h1;
	assign txd = txd_r;
	assign done = done_r;
	// a new write restarts the frame at once, even mid-frame
	always_ff @(posedge aclk) begin
		done_r <= 1'b0;
		if (!aresetn) begin
			shift_r <= 11'h7FF;
			cnt_r <= 16'h0000;
			idx_r <= 4'h0;
			busy_r <= 1'b0;
			txd_r <= 1'b1;
		end else if (start) begin
			// short frame: the 1 in the ninth slot goes out as the stop bit, the last slot is never sent
			shift_r <= {1'b1, (long_frame ? ninth : 1'b1), data, 1'b0};
			cnt_r <= 16'h0000;
			idx_r <= 4'h0;
			busy_r <= 1'b1;
			txd_r <= 1'b0;
		end else if (tick) begin
			cnt_r <= 16'h0000;
			if (idx_r == last_idx) begin
				busy_r <= 1'b0;
				txd_r <= 1'b1;
				done_r <= 1'b1;
			end else begin
				idx_r <= idx_r + 4'h1;
				shift_r <= {1'b1, shift_r[10:1]};
				txd_r <= shift_r[1];
			end
		end else if (busy_r) begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_tx_start;
		start |=> !txd && busy_r && idx_r == 4'h0;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("no start bit after write");
	property p_tx_bit_time;
		busy_r && !$past(start) && $past(busy_r) && idx_r != $past(idx_r) |->
			$past(cnt_r) == divisor - 16'h0001;
	endproperty
	a_tx_bit_time: assert property (p_tx_bit_time) else $error("bit shorter than divisor");
	property p_tx_len;
		done |-> txd && $past(idx_r) == (long_frame ? 4'hA : 4'h9);
	endproperty
	a_tx_len: assert property (p_tx_len) else $error("frame length wrong");
endmodule : ubd_tx

// ---- rtl/ubd_rx.sv ----
// serial receiver: samples mid bit, reports frames with a good stop bit
`timescale 1ns/1ps
`include "ubd_consts.svh"
module ubd_rx import ubd_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] divisor,
	input wire logic long_frame,
	input wire logic enable,
	input wire logic rxd,
	output logic [7:0] data,
	output logic ninth,
	output logic done
);
	// ----------------------------------------
	// receive state machine
	// ----------------------------------------
	ubd_rx_state_t state_r;
	logic rxd_prev_r; // for falling edge of start bit
	logic [15:0] cnt_r;
	logic [3:0] idx_r;
	logic [8:0] shift_r; // lsb first, newest at top
	logic [7:0] data_r;
	logic ninth_r;
	logic done_r;
	logic bit_end;
	assign bit_end = (cnt_r == divisor - 16'h0001);
	assign data = data_r;
	assign ninth = ninth_r;
	assign done = done_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxd_prev_r <= 1'b1;
		end else begin
			rxd_prev_r <= rxd;
		end
	end
	// divisor above 16 keeps the half-bit point well inside the bit
	always_ff @(posedge aclk) begin
		done_r <= 1'b0;
		if (!aresetn) begin
			state_r <= RX_IDLE;
			cnt_r <= 16'h0000;
			idx_r <= 4'h0;
			shift_r <= 9'h000;
			data_r <= `UBD_RST_BYTE;
			ninth_r <= 1'b0;
		end else if (!enable) begin
			state_r <= RX_IDLE;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
			unique case (state_r)
				RX_IDLE: begin
					cnt_r <= 16'h0000;
					if (rxd_prev_r && !rxd) begin
						state_r <= RX_START;
					end
				end
				RX_START: begin
					// glitch rejection: line must still be low mid bit
					if (cnt_r == {1'b0, divisor[15:1]}) begin
						cnt_r <= 16'h0000;
						idx_r <= 4'h0;
						state_r <= rxd ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (bit_end) begin
						cnt_r <= 16'h0000;
						shift_r <= {rxd, shift_r[8:1]};
						idx_r <= idx_r + 4'h1;
						if (idx_r == (long_frame ? 4'h8 : 4'h7)) begin
							state_r <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (bit_end) begin
						state_r <= RX_IDLE;
						if (rxd) begin
							data_r <= long_frame ? shift_r[7:0] : shift_r[8:1];
							ninth_r <= shift_r[8];
							done_r <= 1'b1;
						end
					end
				end
			endcase
		end
	end
	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rx_disabled;
		!enable |=> state_r == RX_IDLE && !done;
	endproperty
	a_rx_disabled: assert property (p_rx_disabled) else $error("receiver active while off");
endmodule : ubd_rx

// ---- bench/ubd_far_end.sv ----
// remote serial transceiver model facing the serial port
`timescale 1ns/1ps
module ubd_far_end #(
	parameter int BIT_NS = 12950 // one bit time in ns
) (
	input wire logic line_in, // the port's transmit pin
	output logic line_out // the port's receive pin
);
	logic long_mode = 1'b0; // eleven bit frames when set
	logic [7:0] got_byte = 8'h00; // last byte heard
	logic got_ninth = 1'b0; // last ninth bit heard
	logic [7:0] sh = 8'h00; // bits being gathered
	logic n9 = 1'b0; // ninth bit being gathered
	initial line_out = 1'b1;
	// ----------------------------------------
	// sender: start, data lsb first, ninth in long mode, stop
	// ----------------------------------------
	// the small lead-in keeps line edges away from clock edges
	task automatic send(input logic [7:0] d, input logic nb);
		#7;
		line_out = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++) begin
			line_out = d[i];
			#(BIT_NS);
		end
		if (long_mode) begin
			line_out = nb;
			#(BIT_NS);
		end
		line_out = 1'b1;
		#(BIT_NS);
	endtask : send
	// ----------------------------------------
	// receiver: mid-bit sampling, good stop only
	// ----------------------------------------
	always begin
		@(negedge line_in);
		#(BIT_NS / 2);
		for (int i = 0; i < 8; i++) begin
			#(BIT_NS);
			sh[i] = line_in;
		end
		if (long_mode) begin
			#(BIT_NS);
			n9 = line_in;
		end
		#(BIT_NS);
		// a broken stop bit leaves the last good frame in place
		if (line_in === 1'b1) begin
			got_byte = sh;
			got_ninth = n9;
		end
	end
endmodule : ubd_far_end

// ---- bench/uart_baud_and_data_buffer_bench.sv ----
// self-checking bench for the serial port
`timescale 1ns/1ps
`include "ubd_consts.svh"
module uart_baud_and_data_buffer_bench;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int DIV = 259; // bit time in clocks, divisor 16'h0103
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h000;
	logic [11:0] araddr = 12'h000;
	logic [31:0] wdata = 32'h00000000;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, rxd, txd, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	int n_errors = 0, num_checks = 0, low_run = 0, low_len = 0;
	always #25 aclk = ~aclk;
	ubd_top ubd_top_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .rxd(rxd), .txd(txd), .irq(irq));
	ubd_far_end #(.BIT_NS(DIV * 50)) ubd_far_end_inst (.line_in(txd), .line_out(rxd));
	// latest low stretch on the transmit pin, in clocks
	always @(posedge aclk) begin
		if (txd === 1'b0) begin
			low_run <= low_run + 1;
		end else if (low_run != 0) begin
			low_len <= low_run;
			low_run <= 0;
		end
	end
	// ----------------------------------------
	// reporting
	// ----------------------------------------
	task automatic stop_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic hang(input string what);
		n_errors++;
		$display("CHECK FAILED %s expected answer seen timeout", what);
		stop_test();
	endtask : hang
	// ----------------------------------------
	// axi4-lite master, one transfer at a time
	// ----------------------------------------
	task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic got;
		got = 1'b0;
		@(posedge aclk);
		awaddr <= {2'b00, idx, 2'b00};
		wdata <= {24'h000000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 50 && !got; n++) begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				got = 1'b1;
				bready <= 1'b0;
				chk("bresp", 32'(er), 32'(bresp));
			end
		end
		if (!got) hang("write");
	endtask : wr
	task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] rs);
		logic got;
		got = 1'b0;
		@(posedge aclk);
		araddr <= {2'b00, idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 50 && !got; n++) begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				got = 1'b1;
				rready <= 1'b0;
				d = rdata;
				rs = rresp;
			end
		end
		if (!got) hang("read");
	endtask : rd
	task automatic rchk(input string what, input logic [7:0] idx, input logic [7:0] e,
		input logic [1:0] er);
		logic [31:0] v;
		logic [1:0] rs;
		rd(idx, v, rs);
		chk(what, 32'(e), v);
		chk("rresp", 32'(er), 32'(rs));
	endtask : rchk
	// polls the control register until bit b is set
	task automatic wait_ctl(input int b);
		logic [31:0] v;
		logic [1:0] rs;
		for (int n = 0; n < 2000; n++) begin
			rd(`UBD_IDX_CTL, v, rs);
			if (v[b] === 1'b1) return;
		end
		hang("flag wait");
	endtask : wait_ctl
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_regs();
		rchk("div_hi", `UBD_IDX_DIV_HI, 8'h00, `UBD_RESP_OKAY);
		rchk("div_lo", `UBD_IDX_DIV_LO, 8'h00, `UBD_RESP_OKAY);
		rchk("data", `UBD_IDX_DATA, 8'h00, `UBD_RESP_OKAY);
		rchk("ctl", `UBD_IDX_CTL, 8'h00, `UBD_RESP_OKAY);
		rchk("stat", `UBD_IDX_IRQ_STAT, 8'h00, `UBD_RESP_OKAY);
		rchk("mask", `UBD_IDX_IRQ_MASK, 8'h00, `UBD_RESP_OKAY);
		wr(8'h10, 8'h55, `UBD_RESP_SLVERR);
		rchk("unmapped", 8'h10, 8'h00, `UBD_RESP_SLVERR);
		wr(`UBD_IDX_CTL, 8'h03, `UBD_RESP_OKAY);
		rchk("ctl flags", `UBD_IDX_CTL, 8'h03, `UBD_RESP_OKAY);
		wr(`UBD_IDX_CTL, 8'h00, `UBD_RESP_OKAY);
		// divisor 0x0103 stays well above the 0x0010 floor
		wr(`UBD_IDX_DIV_HI, 8'h01, `UBD_RESP_OKAY);
		wr(`UBD_IDX_DIV_LO, 8'h03, `UBD_RESP_OKAY);
		rchk("div_hi", `UBD_IDX_DIV_HI, 8'h01, `UBD_RESP_OKAY);
	endtask : t_regs
	// short frame out, bit rate, sticky flag and interrupt path
	task automatic t_tx_short();
		wr(`UBD_IDX_DATA, 8'h01, `UBD_RESP_OKAY);
		wait_ctl(`UBD_CTL_TI);
		chk("tx byte", 32'h01, 32'(ubd_far_end_inst.got_byte));
		chk("low run", 32'(7 * DIV), 32'(low_len));
		rchk("data read", `UBD_IDX_DATA, 8'h00, `UBD_RESP_OKAY);
		rchk("stat", `UBD_IDX_IRQ_STAT, 8'h02, `UBD_RESP_OKAY);
		chk("irq masked", 32'h0, 32'(irq));
		wr(`UBD_IDX_IRQ_MASK, 8'h02, `UBD_RESP_OKAY);
		chk("irq", 32'h1, 32'(irq));
		wr(`UBD_IDX_IRQ_STAT, 8'h02, `UBD_RESP_OKAY);
		chk("irq cleared", 32'h0, 32'(irq));
		repeat (100) @(posedge aclk);
		rchk("ctl sticky", `UBD_IDX_CTL, 8'h02, `UBD_RESP_OKAY);
		wr(`UBD_IDX_CTL, 8'h00, `UBD_RESP_OKAY);
		rchk("ctl clear", `UBD_IDX_CTL, 8'h00, `UBD_RESP_OKAY);
	endtask : t_tx_short
	// long frames out with both ninth bit values
	task automatic t_tx_long();
		ubd_far_end_inst.long_mode = 1'b1;
		for (int i = 0; i < 2; i++) begin
			wr(`UBD_IDX_CTL, i[0] ? 8'h88 : 8'h80, `UBD_RESP_OKAY);
			wr(`UBD_IDX_DATA, i[0] ? 8'h3C : 8'hC3, `UBD_RESP_OKAY);
			wait_ctl(`UBD_CTL_TI);
			chk("tx byte", i[0] ? 32'h3C : 32'hC3, 32'(ubd_far_end_inst.got_byte));
			chk("tx ninth", 32'(i[0]), 32'(ubd_far_end_inst.got_ninth));
		end
	endtask : t_tx_long
	// receive, disabled receive, then the multiprocessor filter table
	task automatic t_rx();
		logic [7:0] last;
		logic [7:0] c;
		logic [7:0] by[3] = '{8'h22, 8'h33, 8'h44};
		logic mp[3] = '{1'b1, 1'b1, 1'b0};
		logic nb[3] = '{1'b0, 1'b1, 1'b0};
		logic fl[3] = '{1'b0, 1'b1, 1'b1};
		last = 8'h5A;
		ubd_far_end_inst.long_mode = 1'b0;
		wr(`UBD_IDX_CTL, 8'h10, `UBD_RESP_OKAY);
		ubd_far_end_inst.send(8'h5A, 1'b0);
		wait_ctl(`UBD_CTL_RI);
		rchk("ctl rx", `UBD_IDX_CTL, 8'h11, `UBD_RESP_OKAY);
		rchk("rx data", `UBD_IDX_DATA, 8'h5A, `UBD_RESP_OKAY);
		// the tx event bit is still standing from the two long frames
		rchk("stat", `UBD_IDX_IRQ_STAT, 8'h03, `UBD_RESP_OKAY);
		wr(`UBD_IDX_IRQ_STAT, 8'h03, `UBD_RESP_OKAY);
		wr(`UBD_IDX_CTL, 8'h00, `UBD_RESP_OKAY);
		ubd_far_end_inst.send(8'h11, 1'b0);
		repeat (20) @(posedge aclk);
		rchk("ctl off", `UBD_IDX_CTL, 8'h00, `UBD_RESP_OKAY);
		rchk("data off", `UBD_IDX_DATA, 8'h5A, `UBD_RESP_OKAY);
		ubd_far_end_inst.long_mode = 1'b1;
		for (int i = 0; i < 3; i++) begin
			c = {1'b1, 1'b0, mp[i], 5'h10};
			wr(`UBD_IDX_CTL, c, `UBD_RESP_OKAY);
			ubd_far_end_inst.send(by[i], nb[i]);
			if (fl[i]) begin
				wait_ctl(`UBD_CTL_RI);
				last = by[i];
			end else begin
				repeat (20) @(posedge aclk);
			end
			c[`UBD_CTL_RB8] = nb[i];
			c[`UBD_CTL_RI] = fl[i];
			rchk("ctl long", `UBD_IDX_CTL, c, `UBD_RESP_OKAY);
			rchk("data long", `UBD_IDX_DATA, last, `UBD_RESP_OKAY);
		end
	endtask : t_rx
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_tx_short();
		t_tx_long();
		t_rx();
		stop_test();
	end
endmodule : uart_baud_and_data_buffer_bench
